/* File: hw/qsc_top.sv */
// The register offsets and the Wishbone register port were left to the implementer.
`timescale 1ns/1ps
`include "qsc_regs.svh"

module qsc_top #(
   parameter int DW = 18,
   parameter int AW = 20,
   parameter int RD_LAT = 2
) (
   input wire logic sys_clk,
   input wire logic resetn,
   input wire logic system_reset_in_n,
   input wire logic clock_synth_locked,
   input wire logic delay_ready,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire qsc_pkg::qsc_wbdat_t wb_dat_i,
   output qsc_pkg::qsc_wbdat_t wb_dat_o,
   output logic wb_ack_o,
   input wire logic wa_not_empty,
   input wire logic wd_not_empty,
   input wire logic ra_not_empty,
   input wire logic rd_ret_full,
   input wire logic [AW-1:0] user_wr_addr,
   input wire logic [4*DW-1:0] user_wr_data,
   input wire logic [AW-1:0] user_rd_addr,
   output logic wa_pop,
   output logic wd_pop,
   output logic ra_pop,
   output logic rd_ret_valid,
   output logic [4*DW-1:0] rd_ret_data,
   output logic user_clk,
   output logic user_rst,
   output logic cal_done,
   output logic compare_error,
   output logic mem_k,
   output logic mem_k_n,
   output logic mem_wr_n,
   output logic mem_rd_n,
   output logic [AW-1:0] mem_addr,
   output logic [DW-1:0] mem_d,
   input wire logic mem_cq,
   input wire logic [DW-1:0] mem_q
);
   import qsc_pkg::*;

   localparam int SW = 8 + 2 * AW + 5 * DW;
   localparam bit DW_OK = (DW == 9) || (DW == 18) || (DW == 36) || (DW == 72);

   typedef struct packed {
      logic [SW-1:0] sy1;
      logic [SW-1:0] sy2;
      logic cq_d;
      logic urst;
      logic [15:0] init_cnt;
      logic [7:0] cal_cnt;
      logic cal;
      logic [2:0] div;
      logic k;
      logic k_n;
      logic uclk;
      qsc_op_e fsm;
      logic bl4_act;
      logic wr_n;
      logic rd_n;
      logic [AW-1:0] addr;
      logic [AW-1:0] addr2;
      logic [DW-1:0] d;
      logic [8*DW-1:0] wq;
      logic [3:0] wbeats;
      logic [1:0] wskip;
      logic cap_busy;
      logic [3:0] cap_wait;
      logic [2:0] cap_beats;
      logic [1:0] cap_idx;
      logic [AW-1:0] cap_addr;
      logic [4*DW-1:0] rbuf;
      logic ret_pend;
      logic rvalid;
      logic [4*DW-1:0] rdata;
      logic wa_pop;
      logic wd_pop;
      logic ra_pop;
      logic st_phase;
      logic [AW-1:0] st_addr;
      logic cmp_err;
      logic ctrl_bl4;
      logic ctrl_st;
      logic ack;
      qsc_wbdat_t dat_o;
   } qsc_state_s;

   qsc_state_s s_r;
   qsc_state_s s_nxt;

   logic rst_s, lock_s, dly_s, cq_s, wa_s, wd_s, ra_s, full_s;
   logic [AW-1:0] wa_addr_s, ra_addr_s;
   logic [4*DW-1:0] wdata_s, st_pat, cap_pat;
   logic [DW-1:0] q_s;
   logic tick, k_fall, k_rise, cq_e, bl4, wr_av, rd_av, wr_iss, rd_iss;
   logic [AW-1:0] wr_src, rd_src;
   logic [4*DW-1:0] wd_src;

   assign {rst_s, lock_s, dly_s, cq_s, wa_s, wd_s, ra_s, full_s,
           wa_addr_s, ra_addr_s, wdata_s, q_s} = s_r.sy2;

   // self-test patterns, one word per beat
   for (genvar i = 0; i < 4; i++) begin : g_pat
      assign st_pat[i*DW +: DW] = DW'({~s_r.st_addr, 2'(i)});
      assign cap_pat[i*DW +: DW] = DW'({~s_r.cap_addr, 2'(i)});
   end

   assign tick = (s_r.div == `QSC_KHALF_CYC - 3'h1);
   assign k_fall = tick && s_r.k;
   assign k_rise = tick && !s_r.k;
   assign cq_e = cq_s ^ s_r.cq_d;
   // burst length only changes while nothing is in flight
   assign bl4 = (s_r.fsm == QSC_IDLE && s_r.wbeats == 4'h0 && !s_r.cap_busy && !s_r.ret_pend)
                ? s_r.ctrl_bl4 : s_r.bl4_act;
   assign wr_av = s_r.cal && !s_r.urst
                  && (s_r.ctrl_st ? !s_r.st_phase : (wa_s && wd_s));
   assign rd_av = s_r.cal && !s_r.urst && !s_r.cap_busy && !s_r.ret_pend
                  && (s_r.ctrl_st ? s_r.st_phase : (ra_s && !full_s));
   // burst four alternates, burst two may do both in one cycle
   assign wr_iss = k_fall && wr_av && (!bl4 || s_r.fsm != QSC_WRITE);
   assign rd_iss = k_fall && rd_av && (bl4 ? (!wr_iss && s_r.fsm != QSC_READ) : 1'b1);
   assign wr_src = s_r.ctrl_st ? s_r.st_addr : wa_addr_s;
   assign rd_src = s_r.ctrl_st ? s_r.st_addr : ra_addr_s;
   assign wd_src = s_r.ctrl_st ? st_pat : wdata_s;

   always_comb begin
      s_nxt = s_r;
      s_nxt.sy1 = {system_reset_in_n, clock_synth_locked, delay_ready, mem_cq,
                   wa_not_empty, wd_not_empty, ra_not_empty, rd_ret_full,
                   user_wr_addr, user_rd_addr, user_wr_data, mem_q};
      s_nxt.sy2 = s_r.sy1;
      s_nxt.cq_d = cq_s;
      s_nxt.urst = !(rst_s && lock_s && dly_s);
      s_nxt.div = tick ? 3'h0 : s_r.div + 3'h1;
      if (tick) begin
         s_nxt.k = !s_r.k;
         s_nxt.k_n = s_r.k;
         s_nxt.uclk = !s_r.k;
      end
      s_nxt.ack = wb_cyc_i && wb_stb_i && !s_r.ack;
      if (s_nxt.ack) begin
         s_nxt.dat_o = '0;
         if (wb_adr_i == `QSC_CTRL_OFS) begin
            s_nxt.dat_o[`QSC_CTRL_BL4_BIT] = s_r.ctrl_bl4;
            s_nxt.dat_o[`QSC_CTRL_ST_BIT] = s_r.ctrl_st;
            if (wb_we_i && wb_sel_i[0]) begin
               s_nxt.ctrl_bl4 = wb_dat_i[`QSC_CTRL_BL4_BIT];
               s_nxt.ctrl_st = wb_dat_i[`QSC_CTRL_ST_BIT];
            end
         end else if (wb_adr_i == `QSC_STAT_OFS) begin
            s_nxt.dat_o[`QSC_STAT_CAL_BIT] = s_r.cal;
            s_nxt.dat_o[`QSC_STAT_ERR_BIT] = s_r.cmp_err;
            s_nxt.dat_o[`QSC_STAT_BUSY_BIT] = s_r.cap_busy || (s_r.wbeats != 4'h0);
            s_nxt.dat_o[`QSC_STAT_OP_LSB +: 2] = s_r.fsm;
            if (wb_we_i && wb_sel_i[0] && wb_dat_i[`QSC_STAT_ERR_BIT]) begin
               s_nxt.cmp_err = 1'b0;
            end
         end
      end
      if (s_r.urst) begin
         s_nxt.init_cnt = 16'h0;
         s_nxt.cal_cnt = 8'h0;
         s_nxt.cal = 1'b0;
         s_nxt.fsm = QSC_IDLE;
         s_nxt.wr_n = 1'b1;
         s_nxt.rd_n = 1'b1;
         s_nxt.wbeats = 4'h0;
         s_nxt.wq = '0;
         s_nxt.wskip = 2'h0;
         s_nxt.cap_busy = 1'b0;
         s_nxt.ret_pend = 1'b0;
         s_nxt.rvalid = 1'b0;
         s_nxt.wa_pop = 1'b0;
         s_nxt.wd_pop = 1'b0;
         s_nxt.ra_pop = 1'b0;
         s_nxt.st_phase = 1'b0;
         s_nxt.st_addr = '0;
         s_nxt.cmp_err = 1'b0;
      end else begin
         if (s_r.init_cnt != 16'(`QSC_INIT_CYC)) begin
            s_nxt.init_cnt = s_r.init_cnt + 16'h1;
         end else if (!s_r.cal && cq_e) begin
            s_nxt.cal_cnt = s_r.cal_cnt + 8'h1;
            s_nxt.cal = (s_r.cal_cnt == `QSC_CAL_EDGES - 8'h1);
         end
         if (k_fall) begin
            s_nxt.bl4_act = bl4;
            if (bl4) begin
               s_nxt.fsm = wr_iss ? QSC_WRITE : (rd_iss ? QSC_READ : QSC_IDLE);
            end else begin
               s_nxt.fsm = (wr_iss || rd_iss) ? QSC_RW : QSC_IDLE;
            end
            s_nxt.wr_n = !wr_iss;
            s_nxt.rd_n = !rd_iss;
            s_nxt.wa_pop = wr_iss && !s_r.ctrl_st;
            s_nxt.wd_pop = wr_iss && !s_r.ctrl_st;
            s_nxt.ra_pop = rd_iss && !s_r.ctrl_st;
            s_nxt.addr = rd_iss ? rd_src : wr_src;
            s_nxt.addr2 = wr_iss ? wr_src : rd_src;
            s_nxt.rvalid = 1'b0;
            if (s_r.ret_pend) begin
               s_nxt.ret_pend = 1'b0;
               if (s_r.ctrl_st) begin
                  if (s_r.bl4_act ? (s_r.rbuf != cap_pat)
                      : (s_r.rbuf[2*DW-1:0] != cap_pat[2*DW-1:0])) begin
                     s_nxt.cmp_err = 1'b1;
                  end
               end else begin
                  s_nxt.rvalid = 1'b1;
                  s_nxt.rdata = s_r.rbuf;
               end
            end
            if (wr_iss) begin
               // append behind any beats still draining; burst two carries words 0 and 1 only
               s_nxt.wq = s_r.wq | ((8*DW)'(bl4 ? wd_src : (4*DW)'(wd_src[2*DW-1:0]))
                          << (s_r.wbeats * DW));
               s_nxt.wbeats = s_r.wbeats + (bl4 ? 4'h4 : 4'h2);
               s_nxt.wskip = (bl4 && s_r.wbeats == 4'h0) ? 2'h2 : 2'h0;
               s_nxt.st_phase = s_r.ctrl_st;
            end
            if (rd_iss) begin
               s_nxt.cap_busy = 1'b1;
               s_nxt.cap_wait = 4'(RD_LAT);
               s_nxt.cap_beats = bl4 ? 3'h4 : 3'h2;
               s_nxt.cap_idx = 2'h0;
               s_nxt.cap_addr = rd_src;
               if (s_r.ctrl_st) begin
                  s_nxt.st_phase = 1'b0;
                  s_nxt.st_addr = s_r.st_addr + AW'(1);
               end
            end
         end
         // burst two: read address first half, write address second half
         if (k_rise && !s_r.bl4_act) begin
            s_nxt.addr = s_r.addr2;
         end
         if (tick) begin
            if (s_nxt.wskip != 2'h0) begin
               s_nxt.wskip = s_nxt.wskip - 2'h1;
            end else if (s_nxt.wbeats != 4'h0) begin
               s_nxt.d = s_nxt.wq[DW-1:0];
               s_nxt.wq = s_nxt.wq >> DW;
               s_nxt.wbeats = s_nxt.wbeats - 4'h1;
            end
         end
         if (cq_e && s_r.cap_busy) begin
            if (s_r.cap_wait != 4'h0) begin
               s_nxt.cap_wait = s_r.cap_wait - 4'h1;
            end else begin
               s_nxt.rbuf[s_r.cap_idx*DW +: DW] = q_s;
               s_nxt.cap_idx = s_r.cap_idx + 2'h1;
               s_nxt.cap_beats = s_r.cap_beats - 3'h1;
               if (s_r.cap_beats == 3'h1) begin
                  s_nxt.cap_busy = 1'b0;
                  s_nxt.ret_pend = 1'b1;
               end
            end
         end
      end
   end

   always_ff @(posedge sys_clk or negedge resetn) begin
      if (!resetn) begin
         s_r <= '0;
         s_r.urst <= 1'b1;
         s_r.wr_n <= 1'b1;
         s_r.rd_n <= 1'b1;
         s_r.k_n <= 1'b1;
         s_r.ctrl_bl4 <= 1'b0;
         s_r.ctrl_st <= 1'b0;
      end else begin
         s_r <= s_nxt;
      end
   end

   assign wb_dat_o = s_r.dat_o;
   assign wb_ack_o = s_r.ack;
   assign wa_pop = s_r.wa_pop;
   assign wd_pop = s_r.wd_pop;
   assign ra_pop = s_r.ra_pop;
   assign rd_ret_valid = s_r.rvalid;
   assign rd_ret_data = s_r.rdata;
   assign user_clk = s_r.uclk;
   assign user_rst = s_r.urst;
   assign cal_done = s_r.cal;
   assign compare_error = s_r.cmp_err;
   assign mem_k = s_r.k;
   assign mem_k_n = s_r.k_n;
   assign mem_wr_n = s_r.wr_n;
   assign mem_rd_n = s_r.rd_n;
   assign mem_addr = s_r.addr;
   assign mem_d = s_r.d;

   default clocking cb @(posedge sys_clk);
   endclocking
   default disable iff (!resetn);

   chk_width_legal: assert property (DW_OK)
      else $error("data width not one of 9, 18, 36, 72");
   chk_reset_combine: assert property (!(rst_s && lock_s && dly_s) |=> user_rst)
      else $error("internal reset not raised by a missing qualifier");
   chk_cal_gate: assert property (!cal_done |=> mem_wr_n && mem_rd_n)
      else $error("memory operation before calibration done");
   chk_idle_quiet: assert property (k_fall && !wr_av && !rd_av |=> mem_wr_n && mem_rd_n)
      else $error("operation issued while nothing pending");
   chk_write_first: assert property (k_fall && bl4 && wr_av && rd_av
      && s_r.fsm == QSC_IDLE |=> !mem_wr_n && mem_rd_n)
      else $error("read taken ahead of an eligible write");
   chk_read_gate: assert property ($fell(mem_rd_n) |-> $past(rd_av))
      else $error("read issued without address or return room");
   chk_only_reads: assert property (k_fall && !wr_av && rd_av
      && (!bl4 || s_r.fsm != QSC_READ) |=> !mem_rd_n)
      else $error("eligible read not issued");
   chk_only_writes: assert property (k_fall && wr_av && !rd_av
      && (!bl4 || s_r.fsm != QSC_WRITE) |=> !mem_wr_n)
      else $error("eligible write not issued");
   chk_ddr_launch: assert property ($changed(mem_d) |-> $changed(mem_k))
      else $error("write data changed away from a clock edge");
   chk_bl2_with_data: assert property (wr_iss && !bl4 && s_r.wbeats == 4'h0
      |=> !mem_wr_n && mem_d == $past(wd_src[DW-1:0]))
      else $error("burst two data not launched with write enable");
   chk_bl4_lead: assert property (wr_iss && bl4 && s_r.wbeats == 4'h0
      |=> !mem_wr_n ##8 mem_d == $past(wd_src[DW-1:0], 9) && mem_wr_n)
      else $error("burst four data not one clock after write enable");
   chk_err_sticky: assert property (compare_error
      && !(wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i)
      && !user_rst |=> compare_error)
      else $error("mismatch flag lost without a clear");
   chk_cal_stays: assert property (cal_done && !user_rst |=> cal_done)
      else $error("calibration done dropped without reset");

endmodule

/* File: hw/qsc_regs.svh */
`ifndef QSC_REGS_SVH
`define QSC_REGS_SVH

// register byte offsets on the wishbone slave
`define QSC_CTRL_OFS 8'h00
`define QSC_STAT_OFS 8'h04

// control register fields
`define QSC_CTRL_BL4_BIT 0
`define QSC_CTRL_ST_BIT 1
`define QSC_CTRL_RST 2'h0

// status register fields
`define QSC_STAT_CAL_BIT 0
`define QSC_STAT_ERR_BIT 1
`define QSC_STAT_BUSY_BIT 2
`define QSC_STAT_OP_LSB 4

// timing
`define QSC_CLK_MHZ 100
`define QSC_INIT_NS 2000
`define QSC_INIT_CYC ((`QSC_INIT_NS * `QSC_CLK_MHZ + 999) / 1000)
`define QSC_KHALF_CYC 3'h4
`define QSC_CAL_EDGES 8'h10

`endif

/* File: hw/qsc_pkg.sv */
package qsc_pkg;
   typedef enum logic [1:0] {
      QSC_IDLE,
      QSC_WRITE,
      QSC_READ,
      QSC_RW
   } qsc_op_e;
   typedef logic [31:0] qsc_wbdat_t;
endpackage

/* File: dv/qsc_sram_model.sv */
`timescale 1ns/1ps
module qsc_sram_model #(
   parameter int DW = 18,
   parameter int AW = 20,
   parameter int RD_LAT = 2
) (
   input wire logic mem_k,
   input wire logic mem_rd_n,
   input wire logic [AW-1:0] mem_addr,
   input wire logic corrupt,
   output logic mem_cq,
   output logic [DW-1:0] mem_q
);
   logic [AW-1:0] rd_addr;
   int beat;
   // echo clock runs free, phase unrelated to the system clock
   initial begin
      mem_cq = 1'b0;
      mem_q = '0;
      rd_addr = '0;
      beat = 99;
      #3;
      forever #40 mem_cq = ~mem_cq;
   end
   always @(posedge mem_k) begin
      if (mem_rd_n === 1'b0) begin
         rd_addr = mem_addr;
         // controller counts from its issue edge, one echo edge before k rises
         beat = 1 - RD_LAT;
      end
   end
   // read words on both echo edges on their own bus, inverse of last word otherwise
   always @(mem_cq) begin
      if (beat >= 0 && beat < 4)
         mem_q <= DW'({~rd_addr, beat[1:0]}) ^ {DW{corrupt}};
      else
         mem_q <= ~mem_q;
      if (beat < 99)
         beat = beat + 1;
   end
endmodule

/* File: dv/qsc_top_tb.sv */
`timescale 1ns/1ps
`include "qsc_regs.svh"
module qsc_top_tb;
   import qsc_pkg::*;
   localparam int DW = 18;
   localparam int AW = 20;
   typedef struct {logic [3:0] req; logic [2:0] pops;} qsc_row_s;
   logic sys_clk, resetn, system_reset_in_n, clock_synth_locked, delay_ready;
   logic wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
   logic [7:0] wb_adr_i;
   logic [3:0] wb_sel_i;
   qsc_wbdat_t wb_dat_i, wb_dat_o, rd_v;
   logic wa_not_empty, wd_not_empty, ra_not_empty, rd_ret_full;
   logic [AW-1:0] user_wr_addr, user_rd_addr, mem_addr;
   logic [4*DW-1:0] user_wr_data, rd_ret_data;
   logic wa_pop, wd_pop, ra_pop, rd_ret_valid, user_clk, user_rst, cal_done, compare_error;
   logic mem_k, mem_k_n, mem_wr_n, mem_rd_n, mem_cq, corrupt;
   logic [DW-1:0] mem_d, mem_q;
   logic [2:0] seen;
   int errors, cmp_count, early_pops;
   qsc_row_s rows [6];
   qsc_top #(.DW(DW), .AW(AW)) dut (.sys_clk, .resetn, .system_reset_in_n,
      .clock_synth_locked, .delay_ready, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i,
      .wb_sel_i, .wb_dat_i, .wb_dat_o, .wb_ack_o, .wa_not_empty, .wd_not_empty,
      .ra_not_empty, .rd_ret_full, .user_wr_addr, .user_wr_data, .user_rd_addr, .wa_pop,
      .wd_pop, .ra_pop, .rd_ret_valid, .rd_ret_data, .user_clk, .user_rst, .cal_done,
      .compare_error, .mem_k, .mem_k_n, .mem_wr_n, .mem_rd_n, .mem_addr, .mem_d, .mem_cq,
      .mem_q);
   qsc_sram_model #(.DW(DW), .AW(AW)) model (.mem_k, .mem_rd_n, .mem_addr, .corrupt,
      .mem_cq, .mem_q);
   task automatic report_and_stop;
      $display("errors %0d comparisons %0d", errors, cmp_count);
      if (errors == 0 && cmp_count > 0)
         $display("verification passed");
      else
         $display("verification failed");
      $finish;
   endtask
   task automatic check(input logic ok, input string msg);
      cmp_count++;
      if (ok !== 1'b1) begin
         errors++;
         $display("ERROR %0t %s", $time, msg);
      end
   endtask
   task automatic wait_for(ref logic sig, input logic v, input int lim);
      int n;
      n = 0;
      do begin
         @(posedge sys_clk);
         n++;
      end while (sig !== v && n < lim);
      if (sig !== v) begin
         errors++;
         $display("ERROR %0t wait timed out", $time);
         report_and_stop();
      end
   endtask
   task automatic wb(input logic we, input logic [7:0] adr, input qsc_wbdat_t d);
      @(posedge sys_clk);
      wb_cyc_i <= 1'b1;
      wb_stb_i <= 1'b1;
      wb_we_i <= we;
      wb_adr_i <= adr;
      wb_dat_i <= d;
      wait_for(wb_ack_o, 1'b1, 50);
      rd_v = wb_dat_o;
      wb_cyc_i <= 1'b0;
      wb_stb_i <= 1'b0;
      wb_we_i <= 1'b0;
   endtask
   task automatic set_req(input logic [2:0] r);
      {wa_not_empty, wd_not_empty, ra_not_empty} <= r;
   endtask
   initial begin
      sys_clk = 1'b0;
      forever #5 sys_clk = ~sys_clk;
   end
   always @(posedge sys_clk) begin
      if (cal_done !== 1'b1 && (wa_pop | wd_pop | ra_pop) === 1'b1)
         early_pops++;
   end
   initial begin
      rows = '{'{4'h0, 3'h0}, '{4'hC, 3'h6}, '{4'h2, 3'h1}, '{4'h3, 3'h0},
         '{4'hA, 3'h1}, '{4'hE, 3'h7}};
      {resetn, wb_cyc_i, wb_stb_i, wb_we_i, corrupt, rd_ret_full} = '0;
      {system_reset_in_n, clock_synth_locked, delay_ready} = 3'h7;
      {wa_not_empty, wd_not_empty, ra_not_empty} = 3'h7;
      wb_adr_i = 8'h00;
      wb_sel_i = 4'hF;
      wb_dat_i = 32'h0;
      user_wr_addr = 20'h12345;
      user_rd_addr = 20'h0ABCD;
      user_wr_data = 72'h8765_4321_0FED_CBA9_87;
      {errors, cmp_count, early_pops} = '0;
      repeat (4) @(posedge sys_clk);
      resetn <= 1'b1;
      wb(1'b0, `QSC_CTRL_OFS, 32'h0);
      check(rd_v[1:0] === `QSC_CTRL_RST, "control reset value");
      wb(1'b0, 8'h10, 32'h0);
      check(rd_v === 32'h0, "unmapped read not zero");
      wait_for(cal_done, 1'b1, 3000);
      check(early_pops == 0, "operation before calibration done");
      set_req(3'h0);
      wb(1'b0, `QSC_STAT_OFS, 32'h0);
      check(rd_v[`QSC_STAT_CAL_BIT] === 1'b1, "status calibration bit");
      repeat (60) @(posedge sys_clk);
      foreach (rows[i]) begin
         {wa_not_empty, wd_not_empty, ra_not_empty, rd_ret_full} <= rows[i].req;
         seen = 3'h0;
         repeat (24) begin
            @(posedge sys_clk);
            seen = seen | {wa_pop, wd_pop, ra_pop};
            if (wa_pop === 1'b1)
               {wa_not_empty, wd_not_empty} <= 2'h0;
            if (ra_pop === 1'b1)
               ra_not_empty <= 1'b0;
         end
         check(seen === rows[i].pops, "pop pattern");
         set_req(3'h0);
         repeat (60) @(posedge sys_clk);
      end
      rd_ret_full <= 1'b0;
      // burst two: enable with first word, second word at the k rise
      set_req(3'h6);
      wait_for(wa_pop, 1'b1, 40);
      set_req(3'h0);
      check(mem_wr_n === 1'b0 && mem_d === user_wr_data[DW-1:0], "bl2 first word");
      repeat (4) @(posedge sys_clk);
      check(mem_d === user_wr_data[2*DW-1:DW], "bl2 second word");
      check(mem_addr === user_wr_addr, "bl2 write address");
      repeat (60) @(posedge sys_clk);
      wb(1'b1, `QSC_CTRL_OFS, 32'h1);
      repeat (20) @(posedge sys_clk);
      set_req(3'h7);
      wait_for(wa_pop, 1'b1, 40);
      {wa_not_empty, wd_not_empty} <= 2'h0;
      check(ra_pop === 1'b0 && mem_wr_n === 1'b0, "write not first");
      repeat (8) @(posedge sys_clk);
      check(mem_d === user_wr_data[DW-1:0], "bl4 data one clock after enable");
      check(mem_k_n === ~mem_k, "memory clock pair not complementary");
      wait_for(ra_pop, 1'b1, 40);
      ra_not_empty <= 1'b0;
      check(mem_rd_n === 1'b0 && mem_addr === user_rd_addr, "bl4 read address");
      wait_for(rd_ret_valid, 1'b1, 100);
      check(rd_ret_data === {DW'({~user_rd_addr, 2'h3}), DW'({~user_rd_addr, 2'h2}),
         DW'({~user_rd_addr, 2'h1}), DW'({~user_rd_addr, 2'h0})}, "read return data");
      repeat (60) @(posedge sys_clk);
      corrupt <= 1'b1;
      wb(1'b1, `QSC_CTRL_OFS, 32'h3);
      wait_for(compare_error, 1'b1, 3000);
      wb(1'b1, `QSC_CTRL_OFS, 32'h0);
      repeat (80) @(posedge sys_clk);
      wb(1'b1, `QSC_STAT_OFS, 32'h2);
      wb(1'b0, `QSC_STAT_OFS, 32'h0);
      check(rd_v[`QSC_STAT_ERR_BIT] === 1'b0, "mismatch flag not cleared");
      corrupt <= 1'b0;
      wb(1'b1, `QSC_CTRL_OFS, 32'h3);
      repeat (200) @(posedge sys_clk);
      wb(1'b1, `QSC_CTRL_OFS, 32'h0);
      repeat (80) @(posedge sys_clk);
      check(compare_error === 1'b0, "mismatch on clean readback");
      for (int k = 0; k < 3; k++) begin
         {system_reset_in_n, clock_synth_locked, delay_ready} <= ~(3'h1 << k);
         wait_for(user_rst, 1'b1, 10);
         {system_reset_in_n, clock_synth_locked, delay_ready} <= 3'h7;
         wait_for(user_rst, 1'b0, 20);
      end
      wait_for(user_clk, 1'b1, 20);
      wait_for(user_clk, 1'b0, 20);
      report_and_stop();
   end
endmodule
